// *** bcc_host_cfg.svh ***
// Register offsets, field positions, reset values and counts of the coder host control.
`ifndef BCC_HOST_CFG_SVH
`define BCC_HOST_CFG_SVH

`define BCC_OFF_SETUP 4'h0
`define BCC_OFF_PARAM 4'h1
`define BCC_OFF_CMD_STAT 4'h2
`define BCC_OFF_IRQ_EN 4'h3

`define BCC_SETUP_RESET 8'h00
`define BCC_PARAM_RESET 8'h00
`define BCC_IRQ_EN_RESET 4'h0

`define BCC_SU_SOFT_RESET 0
`define BCC_SU_OP_LO 1
`define BCC_SU_OP_HI 2
`define BCC_SU_CTX_SRC 3
`define BCC_SU_BIT_SWAP 4
`define BCC_SU_BYTE_SWAP 5
`define BCC_SU_PORT_SEL 6
`define BCC_SU_BUS_WIDTH 7

`define BCC_PA_AT_LO 0
`define BCC_PA_AT_HI 6
`define BCC_PA_TEMPLATE 6
`define BCC_PA_CTX_LATCH 7

`define BCC_CMD_INIT 0
`define BCC_CMD_RUN 1
`define BCC_CMD_TABLE 2
`define BCC_CMD_PAUSE 3

`define BCC_ST_DONE 0
`define BCC_ST_XFER 1
`define BCC_ST_MARKER 2
`define BCC_ST_IRQ 3
`define BCC_ST_STUFF 4
`define BCC_ST_HALTED 5

`define BCC_STUFF_BYTE 8'hff
`define BCC_STUFF_CNT_W 8
`define BCC_CTX_W 12
`define BCC_PIX_W 32

`endif

// *** bcc_host_pkg.sv ***
// Types shared by the coder host control.
package bcc_host_pkg;

    typedef enum logic [1:0] {
        BCC_OP_CODE = 2'b00,
        BCC_OP_DECODE = 2'b01,
        BCC_OP_THROUGH = 2'b10,
        BCC_OP_SPARE = 2'b11
    } bcc_op_t;

    typedef enum logic [1:0] {
        BCC_RUN_IDLE = 2'b00,
        BCC_RUN_BUSY = 2'b01,
        BCC_RUN_PAUSED = 2'b10,
        BCC_RUN_DRAIN = 2'b11
    } bcc_run_t;

endpackage

// *** bcc_host_ctrl.sv ***
// Host register bank and command sequencing of the bi-level image coder.
`timescale 1ns/1ns
`include "bcc_host_cfg.svh"

module bcc_host_ctrl (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic cs_b_in,
    input wire logic [3:0] addr_in,
    input wire logic wr_b_in,
    input wire logic rd_b_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_out,
    input wire logic wide_host_bus_sel_in,
    output logic irq_line_out,
    output logic core_reset_out,
    output logic [1:0] op_select_out,
    output logic context_source_out,
    output logic image_port_select_out,
    output logic image_bus_width_out,
    output logic template_select_out,
    output logic [6:0] adaptive_pixel_offset_out,
    output logic table_init_start_out,
    output logic run_active_out,
    output logic table_access_out,
    output logic flush_out,
    output logic zero_fill_out,
    input wire logic core_init_done_in,
    input wire logic core_lines_done_in,
    input wire logic core_all_read_in,
    input wire logic core_xfer_ready_in,
    input wire logic core_marker_in,
    input wire logic core_code_byte_valid_in,
    input wire logic [7:0] core_code_byte_in,
    input wire logic core_image_idle_in,
    input wire logic core_code_starved_in,
    input wire logic [15:0] core_rd_word_in,
    output logic [15:0] host_rd_word_out,
    input wire logic [15:0] host_wr_word_in,
    output logic [15:0] core_wr_word_out,
    input wire logic [`BCC_PIX_W-1:0] pix_bus_in,
    output logic [`BCC_PIX_W-1:0] pix_word_out,
    input wire logic [`BCC_CTX_W-1:0] context_in,
    input wire logic context_xfer_clock_in,
    output logic [`BCC_CTX_W-1:0] context_out
);

    // Reset release and pin synchronisers.
    logic rst_meta_q;
    logic rst_sync_q;
    logic [21:0] pin_meta_q;
    logic [21:0] pin_sync_q;
    logic [`BCC_CTX_W:0] ctx_meta_q;
    logic [`BCC_CTX_W:0] ctx_sync_q;
    logic [`BCC_PIX_W-1:0] pix_meta_q;
    logic [`BCC_PIX_W-1:0] pix_sync_q;
    logic wr_b_prev_q;
    logic context_xfer_clock_prev_q;
    logic rst_n;

    // Registers.
    logic [7:0] setup_q;
    logic [7:0] param_q;
    logic [3:0] irq_en_q;
    logic init_cmd_q;
    logic run_cmd_q;
    logic table_cmd_q;
    logic pause_sel_q;
    bcc_host_pkg::bcc_run_t run_state_q;
    logic done_q;
    logic marker_q;
    logic stuff_ovf_q;
    logic halted_q;
    logic [`BCC_STUFF_CNT_W-1:0] stuff_cnt_q;
    logic [`BCC_CTX_W-1:0] ctx_latch_q;

    logic cs_s;
    logic wr_s;
    logic rd_s;
    logic [3:0] addr_s;
    logic [15:0] wdata_s;
    logic wr_done;
    logic soft_rst;
    logic cmd_wr;
    logic init_go;
    logic run_go;
    logic paused_evt;
    logic [7:0] status;
    logic coding;
    logic decoding;
    logic context_xfer_clock_rise;

    // Bits within a byte are mirrored, then halves swapped on a wide bus.
    function automatic logic [15:0] bcc_order(input logic [15:0] w,
                                               input logic bit_sw,
                                               input logic byte_sw,
                                               input logic wide);
        logic [15:0] r;
        r = w;
        if (bit_sw) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = w[7-i];
                r[8+i] = w[15-i];
            end
        end
        if (byte_sw && wide) begin
            r = {r[7:0], r[15:8]};
        end
        if (!wide) begin
            r[15:8] = 8'h00;
        end
        return r;
    endfunction

    // Asynchronous assert, synchronous release of the reset.
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_n = rst_sync_q;

    // Host strobes are asynchronous, so every bit passes two flops first.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_q <= 22'h3;
            pin_sync_q <= 22'h3;
            wr_b_prev_q <= 1'b1;
        end else begin
            pin_meta_q <= {data_in, addr_in, rd_b_in, cs_b_in};
            pin_sync_q <= pin_meta_q;
            wr_b_prev_q <= wr_s;
        end
    end

    // Write strobe is taken through its own two flops, the same depth as data, address and select.
    logic wr_meta_q;
    logic wr_sync_q;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_meta_q <= 1'b1;
            wr_sync_q <= 1'b1;
        end else begin
            wr_meta_q <= wr_b_in;
            wr_sync_q <= wr_meta_q;
        end
    end

    assign cs_s = ~pin_sync_q[0];
    assign rd_s = ~pin_sync_q[1];
    assign addr_s = pin_sync_q[5:2];
    assign wdata_s = pin_sync_q[21:6];
    assign wr_s = wr_sync_q;
    // A write is taken at the trailing edge of the strobe.
    assign wr_done = wr_s && !wr_b_prev_q && cs_s;
    assign cmd_wr = wr_done && (addr_s == `BCC_OFF_CMD_STAT);

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pix_meta_q <= '0;
            pix_sync_q <= '0;
            ctx_meta_q <= '0;
            ctx_sync_q <= '0;
            context_xfer_clock_prev_q <= 1'b0;
        end else begin
            pix_meta_q <= pix_bus_in;
            pix_sync_q <= pix_meta_q;
            ctx_meta_q <= {context_xfer_clock_in, context_in};
            ctx_sync_q <= ctx_meta_q;
            context_xfer_clock_prev_q <= ctx_sync_q[`BCC_CTX_W];
        end
    end

    assign context_xfer_clock_rise = ctx_sync_q[`BCC_CTX_W] && !context_xfer_clock_prev_q;

    // The reset bit itself survives soft reset so the host can release it.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            setup_q <= `BCC_SETUP_RESET;
        end else if (wr_done && addr_s == `BCC_OFF_SETUP) begin
            setup_q <= wdata_s[7:0];
        end else if (soft_rst) begin
            setup_q <= `BCC_SETUP_RESET | 8'h01;
        end
    end

    assign soft_rst = setup_q[`BCC_SU_SOFT_RESET];
    assign coding = setup_q[`BCC_SU_OP_HI:`BCC_SU_OP_LO] ==
                    bcc_host_pkg::BCC_OP_CODE;
    assign decoding = setup_q[`BCC_SU_OP_HI:`BCC_SU_OP_LO] ==
                      bcc_host_pkg::BCC_OP_DECODE;

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            param_q <= `BCC_PARAM_RESET;
            irq_en_q <= `BCC_IRQ_EN_RESET;
        end else if (soft_rst) begin
            param_q <= `BCC_PARAM_RESET;
            irq_en_q <= `BCC_IRQ_EN_RESET;
        end else if (wr_done) begin
            if (addr_s == `BCC_OFF_PARAM) begin
                param_q <= wdata_s[7:0];
            end
            if (addr_s == `BCC_OFF_IRQ_EN) begin
                irq_en_q <= wdata_s[3:0];
            end
        end
    end

    assign init_go = cmd_wr && wdata_s[`BCC_CMD_INIT];
    assign run_go = cmd_wr && wdata_s[`BCC_CMD_RUN];
    assign paused_evt = (run_state_q == bcc_host_pkg::BCC_RUN_BUSY) &&
                        core_lines_done_in && pause_sel_q;

    // A host write of one beats a completion in the same cycle.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            init_cmd_q <= 1'b0;
            table_cmd_q <= 1'b0;
            pause_sel_q <= 1'b0;
        end else if (soft_rst) begin
            init_cmd_q <= 1'b0;
            table_cmd_q <= 1'b0;
            pause_sel_q <= 1'b0;
        end else if (cmd_wr) begin
            init_cmd_q <= wdata_s[`BCC_CMD_INIT] |
                          (init_cmd_q & ~core_init_done_in);
            table_cmd_q <= wdata_s[`BCC_CMD_TABLE];
            pause_sel_q <= wdata_s[`BCC_CMD_PAUSE];
        end else if (core_init_done_in) begin
            init_cmd_q <= 1'b0;
        end
    end

    // Run sequencing: busy, halted at a pause, or draining after the end.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            run_state_q <= bcc_host_pkg::BCC_RUN_IDLE;
            run_cmd_q <= 1'b0;
        end else if (soft_rst) begin
            run_state_q <= bcc_host_pkg::BCC_RUN_IDLE;
            run_cmd_q <= 1'b0;
        end else if (run_go) begin
            run_state_q <= bcc_host_pkg::BCC_RUN_BUSY;
            run_cmd_q <= 1'b1;
        end else begin
            if (cmd_wr) begin
                run_cmd_q <= 1'b0;
            end
            unique case (run_state_q)
                bcc_host_pkg::BCC_RUN_IDLE: begin
                    run_state_q <= bcc_host_pkg::BCC_RUN_IDLE;
                end
                bcc_host_pkg::BCC_RUN_BUSY: begin
                    if (core_lines_done_in && pause_sel_q) begin
                        run_state_q <= bcc_host_pkg::BCC_RUN_PAUSED;
                        run_cmd_q <= 1'b0;
                    end else if (core_lines_done_in) begin
                        run_state_q <= bcc_host_pkg::BCC_RUN_DRAIN;
                        run_cmd_q <= 1'b0;
                    end else if (!run_cmd_q && coding && core_image_idle_in) begin
                        run_state_q <= bcc_host_pkg::BCC_RUN_DRAIN;
                    end
                end
                bcc_host_pkg::BCC_RUN_PAUSED: begin
                    run_state_q <= bcc_host_pkg::BCC_RUN_PAUSED;
                end
                bcc_host_pkg::BCC_RUN_DRAIN: begin
                    if (core_all_read_in) begin
                        run_state_q <= bcc_host_pkg::BCC_RUN_IDLE;
                    end
                end
            endcase
        end
    end

    // Done, marker and halted flags; the setting event wins over a restart.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            marker_q <= 1'b0;
            halted_q <= 1'b0;
        end else if (soft_rst) begin
            done_q <= 1'b0;
            marker_q <= 1'b0;
            halted_q <= 1'b0;
        end else begin
            if ((init_cmd_q && core_init_done_in) ||
                (run_state_q == bcc_host_pkg::BCC_RUN_DRAIN &&
                 core_all_read_in)) begin
                done_q <= 1'b1;
            end else if (init_go || run_go) begin
                done_q <= 1'b0;
            end
            if (decoding && core_marker_in) begin
                marker_q <= 1'b1;
            end else if (run_go) begin
                marker_q <= 1'b0;
            end
            if (paused_evt) begin
                halted_q <= 1'b1;
            end else if (run_go) begin
                halted_q <= 1'b0;
            end
        end
    end

    // Stuffing counter wraps; the overflow is sticky but coding goes on.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            stuff_cnt_q <= '0;
            stuff_ovf_q <= 1'b0;
        end else if (soft_rst) begin
            stuff_cnt_q <= '0;
            stuff_ovf_q <= 1'b0;
        end else if (coding && core_code_byte_valid_in &&
                     core_code_byte_in == `BCC_STUFF_BYTE) begin
            stuff_cnt_q <= stuff_cnt_q + 1'b1;
            if (&stuff_cnt_q) begin
                stuff_ovf_q <= 1'b1;
            end
        end else if (init_go || (run_go && run_state_q ==
                                 bcc_host_pkg::BCC_RUN_IDLE)) begin
            stuff_cnt_q <= '0;
        end
    end

    // A pause raises the done-slot request even though done stays low.
    always_comb begin
        status = 8'h00;
        status[`BCC_ST_DONE] = done_q;
        status[`BCC_ST_XFER] = core_xfer_ready_in;
        status[`BCC_ST_MARKER] = marker_q;
        status[`BCC_ST_STUFF] = stuff_ovf_q;
        status[`BCC_ST_HALTED] = halted_q;
        status[`BCC_ST_IRQ] = (irq_en_q[0] & (done_q | halted_q)) |
                              (irq_en_q[1] & core_xfer_ready_in) |
                              (irq_en_q[2] & marker_q) |
                              (irq_en_q[3] & stuff_ovf_q);
    end

    // Host read port and interrupt line.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 16'h0000;
            data_oe_out <= 1'b0;
            irq_line_out <= 1'b0;
        end else begin
            data_oe_out <= cs_s && rd_s;
            irq_line_out <= status[`BCC_ST_IRQ];
            unique case (addr_s)
                `BCC_OFF_SETUP: data_out <= {8'h00, setup_q};
                `BCC_OFF_PARAM: data_out <= {8'h00, param_q};
                `BCC_OFF_CMD_STAT: data_out <= {8'h00, status};
                `BCC_OFF_IRQ_EN: data_out <= {12'h000, irq_en_q};
                default: data_out <= 16'h0000;
            endcase
        end
    end

    // Configuration and command outputs towards the coding core.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            core_reset_out <= 1'b1;
            op_select_out <= 2'b00;
            context_source_out <= 1'b0;
            image_port_select_out <= 1'b0;
            image_bus_width_out <= 1'b0;
            template_select_out <= 1'b0;
            adaptive_pixel_offset_out <= 7'h00;
            table_init_start_out <= 1'b0;
            run_active_out <= 1'b0;
            table_access_out <= 1'b0;
            flush_out <= 1'b0;
            zero_fill_out <= 1'b0;
        end else begin
            core_reset_out <= soft_rst;
            op_select_out <= setup_q[`BCC_SU_OP_HI:`BCC_SU_OP_LO];
            context_source_out <= setup_q[`BCC_SU_CTX_SRC];
            image_port_select_out <= setup_q[`BCC_SU_PORT_SEL];
            image_bus_width_out <= setup_q[`BCC_SU_BUS_WIDTH];
            template_select_out <= param_q[`BCC_PA_TEMPLATE];
            adaptive_pixel_offset_out <= param_q[`BCC_PA_AT_HI:`BCC_PA_AT_LO];
            table_init_start_out <= init_go;
            // Soft reset masks run and table access at once, ahead of the state clearing.
            run_active_out <= !soft_rst &&
                              run_state_q == bcc_host_pkg::BCC_RUN_BUSY;
            table_access_out <= table_cmd_q && !soft_rst;
            flush_out <= coding && !run_cmd_q && core_image_idle_in &&
                         run_state_q == bcc_host_pkg::BCC_RUN_BUSY;
            zero_fill_out <= decoding && !run_cmd_q && core_code_starved_in &&
                             run_state_q == bcc_host_pkg::BCC_RUN_BUSY;
        end
    end

    // Host data ordering and parallel pixel and context paths.
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            host_rd_word_out <= 16'h0000;
            core_wr_word_out <= 16'h0000;
            pix_word_out <= '0;
            ctx_latch_q <= '0;
            context_out <= '0;
        end else begin
            host_rd_word_out <= bcc_order(core_rd_word_in,
                                          setup_q[`BCC_SU_BIT_SWAP],
                                          setup_q[`BCC_SU_BYTE_SWAP],
                                          wide_host_bus_sel_in);
            core_wr_word_out <= bcc_order(host_wr_word_in,
                                          setup_q[`BCC_SU_BIT_SWAP],
                                          setup_q[`BCC_SU_BYTE_SWAP],
                                          wide_host_bus_sel_in);
            if (setup_q[`BCC_SU_BUS_WIDTH]) begin
                pix_word_out <= {16'h0000, pix_sync_q[15:0]};
            end else begin
                pix_word_out <= pix_sync_q;
            end
            if (context_xfer_clock_rise) begin
                ctx_latch_q <= ctx_sync_q[`BCC_CTX_W-1:0];
            end
            if (param_q[`BCC_PA_CTX_LATCH]) begin
                context_out <= ctx_latch_q;
            end else begin
                context_out <= ctx_sync_q[`BCC_CTX_W-1:0];
            end
        end
    end

endmodule

// *** bcc_host_ctrl_monitor.sv ***
// Port checker for the coder host control.
`timescale 1ns/1ns
`include "bcc_host_cfg.svh"
module bcc_host_ctrl_monitor (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic cs_b_in,
    input wire logic rd_b_in,
    input wire logic [3:0] addr_in,
    input wire logic [15:0] data_out,
    input wire logic data_oe_out,
    input wire logic irq_line_out,
    input wire logic core_reset_out,
    input wire logic [1:0] op_select_out,
    input wire logic run_active_out,
    input wire logic table_access_out,
    input wire logic table_init_start_out,
    input wire logic flush_out,
    input wire logic zero_fill_out,
    input wire logic image_bus_width_out,
    input wire logic [`BCC_PIX_W-1:0] pix_word_out,
    input wire logic core_init_done_in,
    input wire logic core_lines_done_in,
    input wire logic core_all_read_in,
    input wire logic core_marker_in,
    input wire logic core_code_byte_valid_in,
    input wire logic core_xfer_ready_in
);
    logic rd_sel;
    logic irq_src;
    assign rd_sel = !cs_b_in && !rd_b_in;
    assign irq_src = core_init_done_in || core_lines_done_in ||
        core_all_read_in || core_marker_in || core_code_byte_valid_in ||
        core_xfer_ready_in;
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    a_init_pulse_once: assert property (table_init_start_out |=>
        !table_init_start_out) else $error("init start too long");
    a_flush_coding: assert property (flush_out |->
        op_select_out == 2'b00) else $error("flush outside coding");
    a_fill_decoding: assert property (zero_fill_out |->
        op_select_out == 2'b01) else $error("zero fill outside decoding");
    a_pix_upper_zero: assert property (image_bus_width_out [*4] |->
        pix_word_out[31:16] == 16'h0000) else $error("narrow bus upper set");
    a_oe_from_read: assert property (data_oe_out |->
        $past(rd_sel, 3)) else $error("read data driven unasked");
    a_unmapped_zero: assert property (data_oe_out &&
        $past(addr_in, 3) > 4'h3 |-> data_out == 16'h0000)
        else $error("unmapped read nonzero");
    a_soft_reset_idle: assert property (core_reset_out |->
        !run_active_out && !table_access_out) else $error("command in reset");
    a_irq_has_cause: assert property ($rose(irq_line_out) |->
        $past(irq_src, 2)) else $error("interrupt without event");
endmodule

bind bcc_host_ctrl bcc_host_ctrl_monitor u_mon (.*);

// *** bcc_core_model.sv ***
// Behavioural model of the coding core behind the host control.
`timescale 1ns/1ns
module bcc_core_model #(
    parameter int LINES = 600
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic init_start_in,
    input wire logic run_active_in,
    input wire logic finish_in,
    output logic init_done_out,
    output logic lines_done_out,
    output logic all_read_out,
    output logic xfer_ready_out
);
    int icnt = 0;
    int lcnt = 0;
    int acnt = 0;
    // Events move on the falling edge so the control samples them settled.
    always @(negedge core_clk_in) begin
        init_done_out <= icnt == 1;
        icnt = init_start_in ? 4 : (icnt > 0 ? icnt - 1 : 0);
        lcnt = run_active_in ? lcnt + 1 : 0;
        lines_done_out <= lcnt == LINES;
        if (lcnt == LINES) begin
            lcnt = 0;
            acnt = finish_in ? 4 : 0;
        end
        all_read_out <= acnt == 1;
        acnt = acnt > 0 ? acnt - 1 : 0;
        xfer_ready_out <= run_active_in && rst_b_in;
    end
endmodule

// *** bcc_host_ctrl_tb.sv ***
// Self-checking bench for the coder host control.
`timescale 1ns/1ns
`include "bcc_host_cfg.svh"
module tb;
    logic core_clk_in = 1'b0, rst_b_in = 1'b0, cs_b_in = 1'b1;
    logic wr_b_in = 1'b1, rd_b_in = 1'b1, wide_host_bus_sel_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] data_in = 16'h0000, core_rd_word_in = 16'h0000;
    logic [15:0] host_wr_word_in = 16'h0000;
    logic core_marker_in = 1'b0, core_code_byte_valid_in = 1'b0;
    logic core_image_idle_in = 1'b0, core_code_starved_in = 1'b0;
    logic [7:0] core_code_byte_in = 8'hff;
    logic [`BCC_PIX_W-1:0] pix_bus_in = 32'h0;
    logic [`BCC_CTX_W-1:0] context_in = 12'h000;
    logic context_xfer_clock_in = 1'b0, finish = 1'b0;
    logic core_init_done_in, core_lines_done_in, core_all_read_in;
    logic core_xfer_ready_in, data_oe_out, irq_line_out, core_reset_out;
    logic [15:0] data_out, host_rd_word_out, core_wr_word_out;
    logic context_source_out, image_port_select_out, image_bus_width_out;
    logic template_select_out, table_init_start_out, run_active_out;
    logic table_access_out, flush_out, zero_fill_out;
    logic [1:0] op_select_out;
    logic [6:0] adaptive_pixel_offset_out;
    logic [`BCC_PIX_W-1:0] pix_word_out;
    logic [`BCC_CTX_W-1:0] context_out;
    int seed = 4;
    int miscompares = 0;
    int checked = 0;
    logic [15:0] v;
    logic [7:0] s;
    logic [31:0] r;
    logic [1:0] m;
    logic flush_seen = 1'b0;

    // The flush request lasts one cycle, so it is caught as it passes.
    always @(posedge core_clk_in) begin
        if (flush_out === 1'b1) begin
            flush_seen <= 1'b1;
        end
    end

    bcc_host_ctrl u_dut (.*);
    bcc_core_model u_core (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .init_start_in(table_init_start_out), .run_active_in(run_active_out),
        .finish_in(finish), .init_done_out(core_init_done_in),
        .lines_done_out(core_lines_done_in), .all_read_out(core_all_read_in),
        .xfer_ready_out(core_xfer_ready_in));

    initial begin
        forever #2 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        cs_b_in = 1'b0;
        addr_in = a;
        data_in = {8'h00, d};
        wr_b_in = 1'b0;
        repeat (3) @(negedge core_clk_in);
        wr_b_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        cs_b_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        @(negedge core_clk_in);
        cs_b_in = 1'b0;
        rd_b_in = 1'b0;
        addr_in = a;
        repeat (5) @(negedge core_clk_in);
        q = data_out;
        chk("read enable", data_oe_out, 16'h0001);
        cs_b_in = 1'b1;
        rd_b_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
    endtask

    // Swaps commute, so mirroring bytes before exchanging them is safe.
    function automatic logic [15:0] order(input logic [15:0] w,
        input logic bs, input logic bx);
        logic [15:0] q;
        for (int i = 0; i < 16; i++)
            q[i] = bs ? w[(i / 8) * 8 + 7 - i % 8] : w[i];
        q = (bx && wide_host_bus_sel_in) ? {q[7:0], q[15:8]} : q;
        return wide_host_bus_sel_in ? q : {8'h00, q[7:0]};
    endfunction

    task automatic wait_end();
        int n;
        n = 0;
        while (run_active_out === 1'b1 && n < 800) begin
            @(negedge core_clk_in);
            n++;
        end
        chk("run ends", 16'(n < 800), 16'h0001);
        repeat (12) @(negedge core_clk_in);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (12) @(negedge core_clk_in);
        rst_b_in = 1'b1;
        rd(4'h0, v);
        chk("setup", v, 16'h0000);
        rd(4'h2, v);
        chk("status", v, 16'h0000);
        r = $random(seed);
        wr(4'h4 + 4'(r[31:4] % 12), 8'h5a);
        rd(4'h4 + 4'(r[31:4] % 12), v);
        chk("unmapped", v, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            m = (i == 1) ? 2'b01 : (i == 2) ? 2'b10 : 2'b00;
            s = {r[7:6], 2'(i), 1'b0, m, 1'b0};
            wr(4'h0, s);
            rd(4'h0, v);
            chk("setup", v, {8'h00, s});
            chk("mode", op_select_out, m);
            chk("port", image_port_select_out, s[6]);
            chk("width", image_bus_width_out, s[7]);
            wide_host_bus_sel_in = r[8];
            core_rd_word_in = r[31:16];
            host_wr_word_in = r[15:0];
            pix_bus_in = $random(seed);
            @(negedge core_clk_in);
            chk("host rd", host_rd_word_out, order(r[31:16], s[4], s[5]));
            chk("core wr", core_wr_word_out, order(r[15:0], s[4], s[5]));
            repeat (4) @(negedge core_clk_in);
            chk("pix lo", pix_word_out[15:0], pix_bus_in[15:0]);
            chk("pix hi", pix_word_out[31:16], s[7] ? 16'h0 : pix_bus_in[31:16]);
        end
        wr(4'h1, r[7:0]);
        rd(4'h1, v);
        chk("param", v, {8'h00, r[7:0]});
        $display("test setup done");
        wr(4'h0, 8'h00);
        wr(4'h3, 8'h01);
        wr(4'h2, 8'h04);
        chk("table", table_access_out, 16'h0001);
        wr(4'h2, 8'h00);
        chk("table", table_access_out, 16'h0000);
        wr(4'h2, 8'h01);
        repeat (10) @(negedge core_clk_in);
        rd(4'h2, v);
        chk("init", v, 16'h0009);
        chk("irq", irq_line_out, 16'h0001);
        wr(4'h2, 8'h0a);
        chk("run", run_active_out, 16'h0001);
        wait_end();
        rd(4'h2, v);
        chk("paused", v, 16'h0028);
        finish = 1'b1;
        wr(4'h2, 8'h02);
        chk("resume", run_active_out, 16'h0001);
        wait_end();
        rd(4'h2, v);
        chk("ended", v, 16'h0009);
        $display("test commands done");
        core_image_idle_in = 1'b1;
        wr(4'h2, 8'h02);
        wr(4'h2, 8'h00);
        chk("flush", flush_seen, 16'h0001);
        wait_end();
        core_image_idle_in = 1'b0;
        wr(4'h0, 8'h02);
        core_code_starved_in = 1'b1;
        wr(4'h2, 8'h02);
        core_marker_in = 1'b1;
        @(negedge core_clk_in);
        core_marker_in = 1'b0;
        wr(4'h2, 8'h00);
        chk("fill", zero_fill_out, 16'h0001);
        rd(4'h2, v);
        chk("marker", v & 16'h0004, 16'h0004);
        wait_end();
        core_code_starved_in = 1'b0;
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h02);
        core_code_byte_valid_in = 1'b1;
        repeat (255) @(negedge core_clk_in);
        core_code_byte_valid_in = 1'b0;
        rd(4'h2, v);
        chk("stuff", v & 16'h0010, 16'h0000);
        core_code_byte_valid_in = 1'b1;
        @(negedge core_clk_in);
        core_code_byte_valid_in = 1'b0;
        rd(4'h2, v);
        chk("stuff", v & 16'h0010, 16'h0010);
        wait_end();
        $display("test ending done");
        wr(4'h0, 8'h01);
        chk("reset", core_reset_out, 16'h0001);
        rd(4'h1, v);
        chk("param", v, 16'h0000);
        rd(4'h2, v);
        chk("status", v, 16'h0000);
        wr(4'h0, 8'h00);
        chk("reset", core_reset_out, 16'h0000);
        $display("test soft reset done");
        print_verdict();
    end
endmodule
